// ==== hw/carrier_loop_consts.vh ====
`ifndef CARRIER_LOOP_CONSTS_VH
`define CARRIER_LOOP_CONSTS_VH

// Register byte offsets
`define CL_OFF_CONFIG 8'h00
`define CL_OFF_STATUS 8'h04
`define CL_OFF_TRELLIS 8'h08
`define CL_OFF_RS 8'h0C
`define CL_OFF_CONTROL 8'h10
`define CL_OFF_FREQ 8'h14

// Configuration register fields
`define CL_CFG_INIT_PERIOD 0
`define CL_CFG_METHOD 1
`define CL_CFG_AVG_COUNT 2
`define CL_CFG_PULLIN_BW 3
`define CL_CFG_TRACK_BW 4
`define CL_CFG_BLIND_LO 5
`define CL_CFG_BLIND_HI 6
`define CL_CFG_DEC_LO 7
`define CL_CFG_DEC_HI 8
`define CL_CFG_WIDTH 9
`define CL_CFG_RESET 9'h000

// Control register fields
`define CL_CTL_CLR_COUNTERS 0

// Status register fields
`define CL_STS_STATE_LO 0
`define CL_STS_STATE_HI 2
`define CL_STS_SCAN_LO 8
`define CL_STS_SCAN_HI 15

// State codes reported outward
`define CL_CODE_IDLE 3'h0
`define CL_CODE_INITIAL 3'h1
`define CL_CODE_FREQ 3'h2
`define CL_CODE_SCAN 3'h3
`define CL_CODE_PULLIN_4Q 3'h4
`define CL_CODE_PULLIN_DD 3'h6
`define CL_CODE_LOCK 3'h7

// Initial period, in symbols
`define CL_INIT_SHORT_SYMBOLS 16384
`define CL_INIT_LONG_SYMBOLS 32768

// Frequency averaging counts and their log2
`define CL_AVG_SHORT_COUNT 7'h10
`define CL_AVG_LONG_COUNT 7'h40
`define CL_AVG_SHORT_SHIFT 4
`define CL_AVG_LONG_SHIFT 6

// Loop bandwidth index: 0.0015, 0.003, 0.01, 0.02
`define CL_BW_PULLIN_NARROW 2'h0
`define CL_BW_PULLIN_WIDE 2'h1
`define CL_BW_TRACK_NARROW 2'h2
`define CL_BW_TRACK_WIDE 2'h3

// Equaliser step as a right shift: step = 2^-shift
`define CL_BLIND_STEP_BASE 4'hA
`define CL_DEC_STEP_BASE 4'hD

// Gain pulse period in symbols
`define CL_GAIN_PERIOD_SYMBOLS 256

`endif

// ==== hw/event_counter.v ====
`timescale 1ns/1ns
// Saturating event counter with a clear that never loses a coincident event
module event_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Control
  input wire clear_i,
  input wire [7:0] add_i,
  // Count
  output wire [WIDTH-1:0] count_o
);

  reg [WIDTH-1:0] count_r;
  reg [WIDTH:0] sum;

  assign count_o = count_r;

  // Sum with one spare bit to detect saturation
  always @* begin
    sum = {1'b0, count_r} + {{(WIDTH-7){1'b0}}, add_i};
  end

  // Clear loads the coincident increment so it is kept
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_r <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      count_r <= {{(WIDTH-8){1'b0}}, add_i};
    end else if (sum[WIDTH]) begin
      count_r <= {WIDTH{1'b1}};
    end else begin
      count_r <= sum[WIDTH-1:0];
    end
  end

endmodule

// ==== hw/gain_pwm.v ====
`timescale 1ns/1ns
`include "carrier_loop_consts.vh"
// Gain-control pulse whose high width follows the measured level
module gain_pwm (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Symbol pacing and level
  input wire symbol_tick_i,
  input wire [7:0] signal_level_i,
  // Pulse
  output wire pulse_o
);

  reg [7:0] phase_r;
  reg [7:0] level_r;
  reg pulse_r;

  assign pulse_o = pulse_r;

  // Phase wraps every period; level latched at each period start
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      phase_r <= 8'h00;
      level_r <= 8'h00;
      pulse_r <= 1'b0;
    end else if (symbol_tick_i) begin
      phase_r <= phase_r + 8'h01;
      if (phase_r == 8'hFF) begin
        level_r <= signal_level_i;
        pulse_r <= (signal_level_i != 8'h00);
      end else begin
        pulse_r <= ((phase_r + 8'h01) < level_r);
      end
    end
  end

endmodule

// ==== hw/carrier_loop_acquisition_ctrl.v ====
`timescale 1ns/1ns
`include "carrier_loop_consts.vh"
// Functional notes
// [R1] Initial period 16384 or 32768 symbols
// [R2] Timing lock moves idle to initial, blind
// [R3] Acquisition starts after whole initial period
// [R4] Method select 1 uses frequency averaging
// [R5] Otherwise scan counter steps per failure
// [R6] Average 16 or 64 frequency computations
// [R7] Configuring party should prefer 64 averages
// [R8] Pull-in bandwidth 0.0015 or 0.003
// [R9] Tracking bandwidth 0.01 or 0.02
// [R10] Blind step 1/1024 down to 1/128
// [R11] Decision step 1/8192 down to 1/1024
// [R12] Byte port with valid flag
// [R13] Sixteen-bit trellis error count
// [R14] Corrected count split high and low
// [R15] Gain pulse period 256 symbols, proportional
// [R16] Three-bit loop state code reported
// [R17] Restart returns loop to idle
// [R18] Bytes leave on user clock rising edges
// [R19] Pull-in bandwidth until lock, then tracking
// [R20] Blind step while blind, decision when locked
module carrier_loop_acquisition_ctrl #(
  parameter INIT_SHORT_SYMBOLS = `CL_INIT_SHORT_SYMBOLS,
  parameter INIT_LONG_SYMBOLS = `CL_INIT_LONG_SYMBOLS
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Loop events from the datapath
  input wire restart_i,
  input wire symbol_tick_i,
  input wire timing_lock_i,
  input wire freq_est_valid_i,
  input wire [15:0] freq_est_i,
  input wire pullin_dd_ready_i,
  input wire pullin_fail_i,
  input wire carrier_lock_i,
  // Loop controls to the datapath
  output wire [2:0] carrier_loop_state_o,
  output wire eq_blind_mode_o,
  output wire [3:0] eq_step_shift_o,
  output wire loop_enable_o,
  output wire [1:0] loop_bw_index_o,
  output wire [15:0] freq_offset_o,
  // Decoder statistics
  input wire [7:0] trellis_err_add_i,
  input wire [7:0] rs_corr_add_i,
  output wire [15:0] trellis_error_count_o,
  output wire [15:0] rs_corrected_count_hi_o,
  output wire [15:0] rs_corrected_count_lo_o,
  // Byte stream
  input wire byte_in_valid_i,
  input wire [7:0] byte_in_i,
  input wire user_output_clock_i,
  output wire [7:0] output_byte_o,
  output wire output_valid_o,
  // Gain control
  input wire [7:0] signal_level_i,
  output wire gain_control_pulse_o
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_INITIAL = 7'h02;
  localparam [6:0] ST_FREQ = 7'h04;
  localparam [6:0] ST_SCAN = 7'h08;
  localparam [6:0] ST_PULL_4Q = 7'h10;
  localparam [6:0] ST_PULL_DD = 7'h20;
  localparam [6:0] ST_LOCK = 7'h40;

  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [`CL_CFG_WIDTH-1:0] cfg_r;
  reg clr_r;
  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg [2:0] code_r;
  reg [15:0] init_cnt_r;
  reg [6:0] avg_cnt_r;
  reg [21:0] acc_r;
  reg [15:0] avg_r;
  reg [7:0] scan_r;
  reg blind_r;
  reg [3:0] step_r;
  reg loop_en_r;
  reg [1:0] bw_r;
  reg [15:0] freq_r;
  reg [15:0] trellis_o_r;
  reg [15:0] rs_hi_r;
  reg [15:0] rs_lo_r;
  reg uclk_s1_r;
  reg uclk_s2_r;
  reg uclk_s3_r;
  reg [7:0] hold_r;
  reg hold_v_r;
  reg [7:0] obyte_r;
  reg ovalid_r;
  wire [15:0] trellis_cnt;
  wire [31:0] rs_cnt;
  wire [15:0] init_last;
  wire [6:0] avg_target;
  wire apb_wr;
  wire uclk_rise;

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign carrier_loop_state_o = code_r;
  assign eq_blind_mode_o = blind_r;
  assign eq_step_shift_o = step_r;
  assign loop_enable_o = loop_en_r;
  assign loop_bw_index_o = bw_r;
  assign freq_offset_o = freq_r;
  assign trellis_error_count_o = trellis_o_r;
  assign rs_corrected_count_hi_o = rs_hi_r;
  assign rs_corrected_count_lo_o = rs_lo_r;
  assign output_byte_o = obyte_r;
  assign output_valid_o = ovalid_r;

  // Reported code for a one-hot state
  function [2:0] state_code;
    input [6:0] st;
    begin
      case (st)
        ST_IDLE: state_code = `CL_CODE_IDLE;
        ST_INITIAL: state_code = `CL_CODE_INITIAL;
        ST_FREQ: state_code = `CL_CODE_FREQ;
        ST_SCAN: state_code = `CL_CODE_SCAN;
        ST_PULL_4Q: state_code = `CL_CODE_PULLIN_4Q;
        ST_PULL_DD: state_code = `CL_CODE_PULLIN_DD;
        ST_LOCK: state_code = `CL_CODE_LOCK;
        default: state_code = `CL_CODE_IDLE;
      endcase
    end
  endfunction

  // APB write strobe at the access edge
  assign apb_wr = psel_i & penable_i & pready_r & pwrite_i;

  // APB slave: one wait-free access phase, error on unmapped offsets
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      cfg_r <= `CL_CFG_RESET;
      clr_r <= 1'b0;
    end else begin
      pready_r <= psel_i & ~penable_i;
      clr_r <= 1'b0;
      if (psel_i & ~penable_i) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
        case (paddr_i)
          `CL_OFF_CONFIG: prdata_r <= {23'h000000, cfg_r};
          `CL_OFF_STATUS: prdata_r <= {16'h0000, scan_r, 5'h00, code_r};
          `CL_OFF_TRELLIS: prdata_r <= {16'h0000, trellis_cnt};
          `CL_OFF_RS: prdata_r <= rs_cnt;
          `CL_OFF_CONTROL: prdata_r <= 32'h00000000;
          `CL_OFF_FREQ: prdata_r <= {16'h0000, freq_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
      if (apb_wr && paddr_i == `CL_OFF_CONFIG) begin
        cfg_r <= pwdata_i[`CL_CFG_WIDTH-1:0];
      end
      if (apb_wr && paddr_i == `CL_OFF_CONTROL) begin
        clr_r <= pwdata_i[`CL_CTL_CLR_COUNTERS];
      end
    end
  end

  // [R1] initial period length
  assign init_last = cfg_r[`CL_CFG_INIT_PERIOD] ? INIT_LONG_SYMBOLS[15:0] - 16'h0001 :
                     INIT_SHORT_SYMBOLS[15:0] - 16'h0001;
  // [R6] averaging count
  assign avg_target = cfg_r[`CL_CFG_AVG_COUNT] ? `CL_AVG_LONG_COUNT : `CL_AVG_SHORT_COUNT;

  // Next loop state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // [R2] leave idle on timing lock
      ST_IDLE: begin
        if (timing_lock_i) begin
          state_nxt = ST_INITIAL;
        end
      end
      // [R3] [R4] start acquisition after full period
      ST_INITIAL: begin
        if (symbol_tick_i && init_cnt_r == init_last) begin
          state_nxt = cfg_r[`CL_CFG_METHOD] ? ST_FREQ : ST_SCAN;
        end
      end
      ST_FREQ: begin
        if (freq_est_valid_i && avg_cnt_r == avg_target - 7'h01) begin
          state_nxt = ST_PULL_4Q;
        end
      end
      ST_SCAN: begin
        state_nxt = ST_PULL_4Q;
      end
      ST_PULL_4Q, ST_PULL_DD: begin
        if (carrier_lock_i) begin
          state_nxt = ST_LOCK;
        end else if (pullin_fail_i) begin
          state_nxt = cfg_r[`CL_CFG_METHOD] ? ST_FREQ : ST_SCAN;
        end else if (pullin_dd_ready_i) begin
          state_nxt = ST_PULL_DD;
        end
      end
      ST_LOCK: begin
        if (!carrier_lock_i) begin
          state_nxt = cfg_r[`CL_CFG_METHOD] ? ST_FREQ : ST_SCAN;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // [R17] restart or lost timing lock returns to idle
    if (restart_i || !timing_lock_i) begin
      state_nxt = ST_IDLE;
    end
  end

  // State, counters and frequency estimate
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      code_r <= `CL_CODE_IDLE;
      init_cnt_r <= 16'h0000;
      avg_cnt_r <= 7'h00;
      acc_r <= 22'h000000;
      avg_r <= 16'h0000;
      scan_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      // [R16] state code
      code_r <= state_code(state_nxt);
      // [R1] symbol count in initial state
      if (state_r != ST_INITIAL) begin
        init_cnt_r <= 16'h0000;
      end else if (symbol_tick_i) begin
        init_cnt_r <= init_cnt_r + 16'h0001;
      end
      // [R6] accumulate then average
      if (state_r != ST_FREQ) begin
        avg_cnt_r <= 7'h00;
        acc_r <= 22'h000000;
      end else if (freq_est_valid_i) begin
        avg_cnt_r <= avg_cnt_r + 7'h01;
        acc_r <= acc_r + {{6{freq_est_i[15]}}, freq_est_i};
        if (state_nxt == ST_PULL_4Q) begin
          avg_r <= cfg_r[`CL_CFG_AVG_COUNT] ?
                   avg_sum_shift(acc_r + {{6{freq_est_i[15]}}, freq_est_i}, 1'b1) :
                   avg_sum_shift(acc_r + {{6{freq_est_i[15]}}, freq_est_i}, 1'b0);
        end
      end
      // [R5] scan step on each failed pull-in
      if (state_nxt == ST_IDLE) begin
        scan_r <= 8'h00;
      end else if (pullin_fail_i && state_nxt == ST_SCAN &&
                   (state_r == ST_PULL_4Q || state_r == ST_PULL_DD)) begin
        scan_r <= scan_r + 8'h01;
      end
    end
  end

  // Arithmetic mean of the accumulator
  function [15:0] avg_sum_shift;
    input [21:0] sum;
    input long_sel;
    begin
      if (long_sel) begin
        avg_sum_shift = sum[`CL_AVG_LONG_SHIFT+15:`CL_AVG_LONG_SHIFT];
      end else begin
        avg_sum_shift = sum[`CL_AVG_SHORT_SHIFT+15:`CL_AVG_SHORT_SHIFT];
      end
    end
  endfunction

  // Loop and equaliser controls from the state
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      blind_r <= 1'b0;
      step_r <= `CL_BLIND_STEP_BASE;
      loop_en_r <= 1'b0;
      bw_r <= `CL_BW_PULLIN_NARROW;
      freq_r <= 16'h0000;
    end else begin
      // [R2] blind from initial until lock
      blind_r <= (state_r != ST_IDLE) && (state_r != ST_LOCK);
      // [R20] [R10] [R11] step selection
      if (state_r == ST_LOCK) begin
        step_r <= `CL_DEC_STEP_BASE - {2'b00, cfg_r[`CL_CFG_DEC_HI:`CL_CFG_DEC_LO]};
      end else begin
        step_r <= `CL_BLIND_STEP_BASE - {2'b00, cfg_r[`CL_CFG_BLIND_HI:`CL_CFG_BLIND_LO]};
      end
      loop_en_r <= (state_r == ST_PULL_4Q) || (state_r == ST_PULL_DD) || (state_r == ST_LOCK);
      // [R19] [R8] [R9] bandwidth selection
      if (state_r == ST_LOCK) begin
        bw_r <= cfg_r[`CL_CFG_TRACK_BW] ? `CL_BW_TRACK_WIDE : `CL_BW_TRACK_NARROW;
      end else begin
        bw_r <= cfg_r[`CL_CFG_PULLIN_BW] ? `CL_BW_PULLIN_WIDE : `CL_BW_PULLIN_NARROW;
      end
      // [R4] [R5] offset source
      freq_r <= cfg_r[`CL_CFG_METHOD] ? avg_r : {scan_r, 8'h00};
    end
  end

  // [R13] trellis error counter
  event_counter #(
    .WIDTH(16)
  ) u_trellis_cnt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clr_r),
    .add_i(trellis_err_add_i),
    .count_o(trellis_cnt)
  );

  // [R14] corrected error counter
  event_counter #(
    .WIDTH(32)
  ) u_rs_cnt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clr_r),
    .add_i(rs_corr_add_i),
    .count_o(rs_cnt)
  );

  // [R14] split statistics onto output flops
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      trellis_o_r <= 16'h0000;
      rs_hi_r <= 16'h0000;
      rs_lo_r <= 16'h0000;
    end else begin
      trellis_o_r <= trellis_cnt;
      rs_hi_r <= rs_cnt[31:16];
      rs_lo_r <= rs_cnt[15:0];
    end
  end

  // User clock synchroniser and edge detect
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      uclk_s1_r <= 1'b0;
      uclk_s2_r <= 1'b0;
      uclk_s3_r <= 1'b0;
    end else begin
      uclk_s1_r <= user_output_clock_i;
      uclk_s2_r <= uclk_s1_r;
      uclk_s3_r <= uclk_s2_r;
    end
  end
  assign uclk_rise = uclk_s2_r & ~uclk_s3_r;

  // [R18] [R12] hold byte, present it on user clock edge
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      obyte_r <= 8'h00;
      ovalid_r <= 1'b0;
    end else begin
      if (uclk_rise) begin
        obyte_r <= hold_r;
        ovalid_r <= hold_v_r;
      end
      if (byte_in_valid_i) begin
        hold_r <= byte_in_i;
        hold_v_r <= 1'b1;
      end else if (uclk_rise) begin
        hold_v_r <= 1'b0;
      end
    end
  end

  // [R15] gain pulse generator
  gain_pwm u_gain_pwm (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .symbol_tick_i(symbol_tick_i),
    .signal_level_i(signal_level_i),
    .pulse_o(gain_control_pulse_o)
  );

endmodule

// ==== bench/carrier_loop_sva.sv ====
`timescale 1ns/1ns
module carrier_loop_sva #(
  parameter INIT_SHORT_SYMBOLS = 16,
  parameter INIT_LONG_SYMBOLS = 32
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Register bus
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  // Loop events and controls
  input wire restart_i,
  input wire symbol_tick_i,
  input wire timing_lock_i,
  input wire freq_est_valid_i,
  input wire [2:0] carrier_loop_state_o,
  input wire eq_blind_mode_o,
  input wire [3:0] eq_step_shift_o,
  input wire loop_enable_o,
  input wire [1:0] loop_bw_index_o
);
  logic [8:0] cfg_r;
  logic [8:0] cfg_q_r;
  logic [15:0] tick_r;
  logic [6:0] est_r;
  wire [2:0] st = carrier_loop_state_o;
  wire [15:0] per = cfg_r[0] ? 16'(INIT_LONG_SYMBOLS) : 16'(INIT_SHORT_SYMBOLS);
  wire [6:0] navg = cfg_r[2] ? 7'h40 : 7'h10;
  // Config mirror plus tick and estimate counts per state
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= 9'h000;
      cfg_q_r <= 9'h000;
      tick_r <= 16'h0000;
      est_r <= 7'h00;
    end else begin
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00) begin
        cfg_r <= pwdata_i[8:0];
      end
      cfg_q_r <= cfg_r;
      tick_r <= (st == 3'h1) ? tick_r + {15'h0000, symbol_tick_i} : 16'h0000;
      est_r <= (st == 3'h2) ? est_r + {6'h00, freq_est_valid_i} : 7'h00;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  restart_idle_a: assert property (restart_i |=> st == 3'h0)
    else $error("loop not idle after restart");
  lock_start_a: assert property (st == 3'h0 && timing_lock_i && !restart_i |=> st == 3'h1)
    else $error("timing lock did not start loop");
  init_period_a: assert property ($past(st) == 3'h1 && st inside {3'h2, 3'h3}
    |-> $past(tick_r) == per - 16'h0001 && $past(symbol_tick_i))
    else $error("initial period length wrong");
  method_sel_a: assert property ($past(st) == 3'h1 && st != 3'h1 && st != 3'h0
    |-> st == (cfg_r[1] ? 3'h2 : 3'h3))
    else $error("wrong estimation method");
  avg_count_a: assert property ($past(st) == 3'h2 && st == 3'h4
    |-> $past(est_r) == navg - 7'h01 && $past(freq_est_valid_i))
    else $error("wrong averaging count");
  blind_mode_a: assert property (eq_blind_mode_o == ($past(st) inside {[3'h1:3'h6]}))
    else $error("blind mode wrong");
  eq_step_a: assert property (eq_step_shift_o == ($past(st) == 3'h7 ?
    4'hD - {2'b00, cfg_q_r[8:7]} : 4'hA - {2'b00, cfg_q_r[6:5]}))
    else $error("equaliser step wrong");
  loop_bw_a: assert property (loop_bw_index_o == ($past(st) == 3'h7 ?
    {1'b1, cfg_q_r[4]} : {1'b0, cfg_q_r[3]}))
    else $error("loop bandwidth wrong");
  loop_enable_a: assert property (loop_enable_o == ($past(st) inside {3'h4, 3'h6, 3'h7}))
    else $error("loop enable wrong");
  cover property (st == 3'h7);
  cover property ($past(st) == 3'h2 && st == 3'h4);
  cover property ($past(st) == 3'h4 && st == 3'h3);
endmodule

bind carrier_loop_acquisition_ctrl carrier_loop_sva #(
  .INIT_SHORT_SYMBOLS(INIT_SHORT_SYMBOLS),
  .INIT_LONG_SYMBOLS(INIT_LONG_SYMBOLS)
) i_sva (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .restart_i(restart_i), .symbol_tick_i(symbol_tick_i), .timing_lock_i(timing_lock_i),
  .freq_est_valid_i(freq_est_valid_i), .carrier_loop_state_o(carrier_loop_state_o),
  .eq_blind_mode_o(eq_blind_mode_o), .eq_step_shift_o(eq_step_shift_o),
  .loop_enable_o(loop_enable_o), .loop_bw_index_o(loop_bw_index_o)
);

// ==== bench/byte_sink_model.sv ====
`timescale 1ns/1ns
// Downstream consumer: makes the user clock and takes bytes at its rises
module byte_sink_model (
  // Control and stream
  input wire run_i,
  input wire [7:0] byte_i,
  input wire valid_i,
  // User clock and received bytes
  output logic usr_clk_o = 1'b0,
  output logic [7:0] rx_byte_o = 8'h00,
  output int rx_count_o = 0
);
  // Clock stops low while stalled; even half period keeps it off the ref rising edges
  always #46 usr_clk_o = run_i ? ~usr_clk_o : 1'b0;
  always @(posedge usr_clk_o) begin
    if (valid_i === 1'b1) begin
      rx_byte_o <= byte_i;
      rx_count_o <= rx_count_o + 1;
    end
  end
endmodule

// ==== bench/tb_carrier_loop_acquisition_ctrl.sv ====
`timescale 1ns/1ns
module tb_carrier_loop_acquisition_ctrl;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic restart_i = 1'b0, symbol_tick_i = 1'b0, timing_lock_i = 1'b0, freq_est_valid_i = 1'b0;
  logic dd_i = 1'b0, fail_i = 1'b0, clock_i = 1'b0, bvalid_i = 1'b0, run = 1'b0;
  logic [7:0] paddr_i = 8'h00, tadd_i = 8'h00, radd_i = 8'h00, byte_i = 8'h00, level_i = 8'h00;
  logic [15:0] freq_est_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [8:0] cfg;
  logic [15:0] exp_f;
  logic [64:0] e;
  logic [64:0] rd_q[$];
  logic [7:0] byte_q[$];
  wire [31:0] prdata;
  wire [15:0] foff, tcnt, rs_hi, rs_lo;
  wire [7:0] obyte, rx_byte;
  wire [3:0] step;
  wire [2:0] st;
  wire [1:0] bw;
  wire pready, pslverr, blind, en, ovalid, gpulse, usr_clk;
  int rx_count, nf, sum, tsum, rsum, hi, fail_count = 0, compares = 0;
  carrier_loop_acquisition_ctrl #(.INIT_SHORT_SYMBOLS(16), .INIT_LONG_SYMBOLS(32)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .restart_i(restart_i),
    .symbol_tick_i(symbol_tick_i), .timing_lock_i(timing_lock_i),
    .freq_est_valid_i(freq_est_valid_i), .freq_est_i(freq_est_i), .pullin_dd_ready_i(dd_i),
    .pullin_fail_i(fail_i), .carrier_lock_i(clock_i), .carrier_loop_state_o(st),
    .eq_blind_mode_o(blind), .eq_step_shift_o(step), .loop_enable_o(en),
    .loop_bw_index_o(bw), .freq_offset_o(foff), .trellis_err_add_i(tadd_i),
    .rs_corr_add_i(radd_i), .trellis_error_count_o(tcnt), .rs_corrected_count_hi_o(rs_hi),
    .rs_corrected_count_lo_o(rs_lo), .byte_in_valid_i(bvalid_i), .byte_in_i(byte_i),
    .user_output_clock_i(usr_clk), .output_byte_o(obyte), .output_valid_o(ovalid),
    .signal_level_i(level_i), .gain_control_pulse_o(gpulse)
  );
  byte_sink_model i_sink (.run_i(run), .byte_i(obyte), .valid_i(ovalid), .usr_clk_o(usr_clk),
    .rx_byte_o(rx_byte), .rx_count_o(rx_count));
  // Clock and symbol pacing
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) symbol_tick_i <= ~symbol_tick_i;
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // One bus transfer, held until ready, then an idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Only the hang guard ends a wait in which ready never rises
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic r);
    rd_q.push_back({r, m, x});
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic wait_st(input logic [2:0] s);
    do begin
      @(posedge ref_clk_i);
    end while (st !== s);
  endtask
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Completed reads against the oldest expectation
  always @(posedge ref_clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready === 1'b1) begin
      e = rd_q.pop_front();
      chk(e[31:0], prdata & e[63:32]);
      chk({31'h0, e[64]}, {31'h0, pslverr});
    end
  end
  // Each byte taken downstream against the oldest sent byte
  always @(rx_count) if (rx_count > 0) chk({24'h0, byte_q.pop_front()}, {24'h0, rx_byte});
  // Hang guard
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(67));
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    for (int a = 0; a < 7; a++) rd(8'(a * 4), 32'h0, 32'hFFFFFFFF, a == 6);
    tsum = 0;
    rsum = 0;
    repeat (40) begin
      tadd_i <= 8'($urandom());
      radd_i <= 8'($urandom());
      @(posedge ref_clk_i);
      tsum += tadd_i;
      rsum += radd_i;
    end
    tadd_i <= 8'h00;
    radd_i <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
    chk(32'(rsum), {rs_hi, rs_lo});
    chk(32'(tsum), {16'h0, tcnt});
    rd(8'h08, 32'(tsum), 32'h0000FFFF, 1'b0);
    rd(8'h0C, 32'(rsum), 32'hFFFFFFFF, 1'b0);
    apb(1'b1, 8'h10, 32'h00000001);
    rd(8'h08, 32'h0, 32'hFFFFFFFF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg = {6'($urandom()), i[0], ~i[1], i[0]};
      apb(1'b1, 8'h00, {23'h0, cfg});
      rd(8'h00, {23'h0, cfg}, 32'h000001FF, 1'b0);
      timing_lock_i <= 1'b1;
      wait_st(cfg[1] ? 3'h2 : 3'h3);
      sum = 0;
      nf = cfg[1] ? 0 : 1 + i[0];
      if (cfg[1]) begin
        repeat (cfg[2] ? 64 : 16) begin
          freq_est_i <= 16'($urandom());
          freq_est_valid_i <= 1'b1;
          @(posedge ref_clk_i);
          sum += $signed(freq_est_i);
        end
        freq_est_valid_i <= 1'b0;
      end
      for (int k = 0; k < nf; k++) begin
        wait_st(3'h4);
        fail_i <= 1'b1;
        @(posedge ref_clk_i);
        fail_i <= 1'b0;
      end
      exp_f = cfg[1] ? 16'(sum >>> (cfg[2] ? 6 : 4)) : {8'(nf), 8'h00};
      wait_st(3'h4);
      dd_i <= 1'b1;
      @(posedge ref_clk_i);
      dd_i <= 1'b0;
      wait_st(3'h6);
      clock_i <= 1'b1;
      wait_st(3'h7);
      rd(8'h04, {16'h0, 8'(nf), 8'h07}, 32'h0000FF07, 1'b0);
      rd(8'h14, {16'h0, exp_f}, 32'h0000FFFF, 1'b0);
      chk({16'h0, exp_f}, {16'h0, foff});
      restart_i <= 1'b1;
      clock_i <= 1'b0;
      timing_lock_i <= 1'b0;
      @(posedge ref_clk_i);
      restart_i <= 1'b0;
      rd(8'h04, 32'h0, 32'h00000007, 1'b0);
    end
    // Stalled consumer: the first byte is overwritten, then steady flow
    for (int b = 0; b < 6; b++) begin
      byte_i <= 8'($urandom());
      bvalid_i <= 1'b1;
      @(posedge ref_clk_i);
      if (b > 0) begin
        bvalid_i <= 1'b0;
        byte_q.push_back(byte_i);
        run <= 1'b1;
        repeat (30) @(posedge ref_clk_i);
      end
    end
    chk(32'(rx_count), 32'h5);
    level_i <= 8'($urandom());
    repeat (1100) @(posedge ref_clk_i);
    hi = 0;
    // Ticks come every other edge, so 512 edges span one full period
    repeat (512) begin
      @(posedge ref_clk_i);
      if (symbol_tick_i) hi += gpulse;
    end
    chk({24'h0, level_i}, 32'(hi));
    print_verdict();
  end
endmodule
